/* logic/bpil_map.svh */
// constants of the belt printer line block: times, counts, offsets, fields
`ifndef BPIL_MAP_SVH
`define BPIL_MAP_SVH
// ****************************************
// clock and times
// ****************************************
`define BPIL_CLK_MHZ 250
`define BPIL_IMP_MIN_US 140
`define BPIL_IMP_MAX_US 423
`define BPIL_MARK_US 600
`define BPIL_BELT_STEP_US 20
`define BPIL_CAR_STEP_US 1000
`define BPIL_CAR_DECEL_US 2000
// ****************************************
// counts
// ****************************************
`define BPIL_LINE_LAST 3'h7
`define BPIL_DECEL_FROM 3'h6
`define BPIL_HAMMERS 132
`define BPIL_GROUP 44
`define BPIL_GROUPS 3
// ****************************************
// register map and fields
// ****************************************
`define BPIL_OFF_WIDTH 8'h00
`define BPIL_OFF_STATUS 8'h04
`define BPIL_OFF_HOMES 8'h08
`define BPIL_WIDTH_RST 9'h08c
`define BPIL_ST_MOTION 0
`define BPIL_ST_CAR_RUN 1
`define BPIL_ST_CAR_DECEL 2
`define BPIL_ST_ODD 3
`define BPIL_ST_THROAT 6
`define BPIL_ST_COVER 7
`define BPIL_ST_FORMS 8
`define BPIL_ST_HOT 9
`endif

/* logic/bpil_oneshot.sv */
// retriggerable single shot with a width given in cycles
module bpil_oneshot (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic start,
    input wire logic [16:0] width,
    output logic active
);
    logic [16:0] cnt_q;
    logic [16:0] cnt_d;
    logic active_d;

    // load on start, run down to zero
    always_comb begin
        cnt_d = cnt_q;
        active_d = active;
        if (start) begin
            cnt_d = width;
            active_d = 1'b1;
        end else if (cnt_q != 17'h0) begin
            cnt_d = cnt_q - 17'h1;
            active_d = (cnt_q != 17'h1);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            active <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            active <= active_d;
        end
    end
endmodule : bpil_oneshot

/* logic/bpil_osc.sv */
// gated oscillator: one-cycle tick every period while enabled
module bpil_osc #(
    parameter int unsigned PERIOD = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic enable,
    output logic tick
);
    logic [19:0] cnt_q;
    logic [19:0] cnt_d;
    logic tick_d;

    // count while gated, restart from zero when stopped
    always_comb begin
        cnt_d = '0;
        tick_d = 1'b0;
        if (enable) begin
            if (cnt_q == 20'(PERIOD - 1)) begin
                tick_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 20'h1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick <= tick_d;
        end
    end
endmodule : bpil_osc

/* logic/bpil_pkg.sv */
// types shared by the belt printer line block
package bpil_pkg;
    // carriage motion states
    typedef enum logic [1:0] {BPIL_C_IDLE, BPIL_C_RUN, BPIL_C_DECEL} bpil_car_state_t;
endpackage : bpil_pkg

/* logic/bpil_top.sv */
// belt printer side of the attachment lines, with an ahb-lite register slave
// Notes on behaviour
// - belt request runs belt oscillator drive pulses
// - motion at speed, drops ten percent slow
// - home and subscan only when up to speed
// - subscan per mark, dummy fills home gap
// - impression starts mid-subscan, 140 to 423 us
// - fire line n drives hammer n
// - carriage request runs carriage oscillator drive
// - three lines report odd hammers per group
// - one advance per increment, eight per line
// - dedicated line reports forms present
// - overheat drives line and panel lamp
// - after drop, two delayed pulses follow sixth
`include "bpil_map.svh"
module bpil_top #(
    parameter int unsigned MARK_CYC = `BPIL_MARK_US * `BPIL_CLK_MHZ,
    parameter int unsigned BELT_STEP_CYC = `BPIL_BELT_STEP_US * `BPIL_CLK_MHZ,
    parameter int unsigned CAR_STEP_CYC = `BPIL_CAR_STEP_US * `BPIL_CLK_MHZ,
    parameter int unsigned CAR_DECEL_CYC = `BPIL_CAR_DECEL_US * `BPIL_CLK_MHZ
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic printer_reset_in,
    input wire logic contactor_close,
    input wire logic belt_run_req,
    input wire logic carriage_run_req,
    input wire logic ribbon_stop,
    input wire logic clamp_req,
    input wire logic [`BPIL_HAMMERS-1:0] hammer_fire,
    input wire logic timing_mark,
    input wire logic throat_sw,
    input wire logic cover_sw,
    input wire logic forms_sw,
    input wire logic thermal_sw,
    output logic belt_drive_step,
    output logic carriage_drive_step,
    output logic belt_in_motion,
    output logic belt_timing_subpulse,
    output logic impression_width_pulse,
    output logic home_pulse,
    output logic carriage_advance,
    output logic [`BPIL_HAMMERS-1:0] hammer_drive,
    output logic [`BPIL_GROUPS-1:0] hammer_group_odd,
    output logic ribbon_halt,
    output logic clamp_drive,
    output logic throat_closed,
    output logic cover_closed,
    output logic forms_present,
    output logic over_temp,
    output logic thermal_fault_lamp
);
    localparam int unsigned RUN_LIM = MARK_CYC;
    localparam int unsigned SLOW_LIM = (MARK_CYC * 10) / 9;
    localparam int unsigned GAP_LIM = (MARK_CYC * 3) / 2;
    localparam int unsigned STALL_LIM = MARK_CYC * 3;
    localparam int unsigned SUB_HALF = MARK_CYC / 2;
    localparam int NPIN = 11;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [NPIN-1:0] pin_meta_q;
    logic [NPIN-1:0] pin_s;
    logic [`BPIL_HAMMERS-1:0] fire_meta_q;
    logic [`BPIL_HAMMERS-1:0] fire_s;
    logic por_s;
    logic power_s;
    logic belt_run_s;
    logic car_run_s;
    logic mark_s;

    // two stages on every pin before use
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_q <= '0;
            pin_s <= '0;
            fire_meta_q <= '0;
            fire_s <= '0;
        end else begin
            pin_meta_q <= {thermal_sw, forms_sw, cover_sw, throat_sw, timing_mark, clamp_req,
                           ribbon_stop, carriage_run_req, belt_run_req, contactor_close,
                           printer_reset_in};
            pin_s <= pin_meta_q;
            fire_meta_q <= hammer_fire;
            fire_s <= fire_meta_q;
        end
    end
    assign por_s = pin_s[0];
    assign power_s = pin_s[1];
    assign belt_run_s = pin_s[2];
    assign car_run_s = pin_s[3];
    assign mark_s = pin_s[6];

    // odd-count flags per hammer group
    function automatic logic [`BPIL_GROUPS-1:0] grp_parity(input logic [`BPIL_HAMMERS-1:0] h);
        for (int g = 0; g < `BPIL_GROUPS; g++) begin
            grp_parity[g] = ^h[g*`BPIL_GROUP +: `BPIL_GROUP];
        end
    endfunction : grp_parity

    // ****************************************
    // hammers, solenoids and switch status
    // ****************************************
    logic [`BPIL_HAMMERS-1:0] hammer_d;

    always_comb begin
        hammer_d = fire_s & {`BPIL_HAMMERS{power_s & ~por_s}};
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hammer_drive <= '0;
            hammer_group_odd <= '0;
            ribbon_halt <= 1'b0;
            clamp_drive <= 1'b0;
            throat_closed <= 1'b0;
            cover_closed <= 1'b0;
            forms_present <= 1'b0;
            over_temp <= 1'b0;
            thermal_fault_lamp <= 1'b0;
        end else begin
            hammer_drive <= hammer_d;
            hammer_group_odd <= grp_parity(hammer_drive);
            ribbon_halt <= pin_s[4];
            clamp_drive <= pin_s[5];
            throat_closed <= pin_s[7];
            cover_closed <= pin_s[8];
            forms_present <= pin_s[9];
            over_temp <= pin_s[10];
            thermal_fault_lamp <= pin_s[10];
        end
    end

    // ****************************************
    // belt speed, subscan, home, impression
    // ****************************************
    logic belt_tick;
    logic mark_prev_q;
    logic mark_rise;
    logic [19:0] interval_q;
    logic [19:0] interval_d;
    logic [19:0] sub_cnt_q;
    logic [19:0] sub_cnt_d;
    logic motion_d;
    logic sub_d;
    logic home_d;
    logic belt_step_d;
    logic imp_start;
    logic [8:0] width_us_q;
    logic [16:0] width_cyc;
    logic [15:0] homes_q;
    logic [15:0] homes_d;

    // belt oscillator gated by the run request
    bpil_osc #(.PERIOD(BELT_STEP_CYC)) u_belt_osc (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(belt_run_s & ~por_s),
        .tick(belt_tick)
    );

    assign mark_rise = mark_s & ~mark_prev_q;
    assign width_cyc = 17'(width_us_q * `BPIL_CLK_MHZ);
    assign imp_start = belt_timing_subpulse & ~sub_d;

    // mark interval measure and subscan generation
    always_comb begin
        interval_d = (interval_q == 20'(STALL_LIM)) ? interval_q : interval_q + 20'h1;
        motion_d = belt_in_motion;
        sub_cnt_d = (sub_cnt_q != 20'h0) ? sub_cnt_q - 20'h1 : sub_cnt_q;
        home_d = 1'b0;
        homes_d = homes_q;
        belt_step_d = belt_drive_step ^ belt_tick;
        // hysteresis on the mark interval, gap intervals skipped
        if (mark_rise) begin
            interval_d = '0;
            if (interval_q <= 20'(RUN_LIM)) begin
                motion_d = 1'b1;
            end else if (interval_q > 20'(SLOW_LIM) && interval_q <= 20'(GAP_LIM)) begin
                motion_d = 1'b0;
            end
        end else if (interval_q == 20'(STALL_LIM)) begin
            motion_d = 1'b0;
        end
        // subscan per mark, dummy plus home in the gap
        if (belt_in_motion && mark_rise) begin
            sub_cnt_d = 20'(SUB_HALF);
        end else if (belt_in_motion && interval_q == 20'(SLOW_LIM + 1)) begin
            sub_cnt_d = 20'(SUB_HALF);
            home_d = 1'b1;
            homes_d = homes_q + 16'h1;
        end
        if (por_s) begin
            motion_d = 1'b0;
            sub_cnt_d = '0;
            home_d = 1'b0;
            interval_d = '0;
        end
        sub_d = (sub_cnt_d != 20'h0);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mark_prev_q <= 1'b0;
            interval_q <= '0;
            sub_cnt_q <= '0;
            belt_in_motion <= 1'b0;
            belt_timing_subpulse <= 1'b0;
            home_pulse <= 1'b0;
            homes_q <= '0;
            belt_drive_step <= 1'b0;
        end else begin
            mark_prev_q <= mark_s;
            interval_q <= interval_d;
            sub_cnt_q <= sub_cnt_d;
            belt_in_motion <= motion_d;
            belt_timing_subpulse <= sub_d;
            home_pulse <= home_d;
            homes_q <= homes_d;
            belt_drive_step <= belt_step_d;
        end
    end

    // impression pulse from the subscan trailing edge
    bpil_oneshot u_imp (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(imp_start),
        .width(width_cyc),
        .active(impression_width_pulse)
    );

    // ****************************************
    // carriage advance and stop
    // ****************************************
    bpil_pkg::bpil_car_state_t car_q;
    bpil_pkg::bpil_car_state_t car_d;
    logic [2:0] phase_q;
    logic [2:0] phase_d;
    logic run_tick;
    logic decel_tick;
    logic adv_d;

    // carriage oscillator runs only in the run state, not while decelerating
    bpil_osc #(.PERIOD(CAR_STEP_CYC)) u_car_osc (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(car_q == bpil_pkg::BPIL_C_RUN),
        .tick(run_tick)
    );

    // slow timer spaces the last two pulses
    bpil_osc #(.PERIOD(CAR_DECEL_CYC)) u_decel_osc (
        .hclk(hclk),
        .hresetn(hresetn),
        .enable(car_q == bpil_pkg::BPIL_C_DECEL),
        .tick(decel_tick)
    );

    // one advance per increment, phase counts the line
    always_comb begin
        car_d = car_q;
        adv_d = 1'b0;
        unique case (car_q)
            bpil_pkg::BPIL_C_IDLE: begin
                if (car_run_s) begin
                    car_d = bpil_pkg::BPIL_C_RUN;
                end
            end
            bpil_pkg::BPIL_C_RUN: begin
                adv_d = run_tick;
                // request gone: decelerate after the sixth
                if (!car_run_s && phase_q == `BPIL_DECEL_FROM) begin
                    car_d = bpil_pkg::BPIL_C_DECEL;
                    adv_d = 1'b0; // decel timer owns the last two
                end else if (!car_run_s && phase_q == 3'h0) begin
                    car_d = bpil_pkg::BPIL_C_IDLE;
                    adv_d = 1'b0;
                end
            end
            bpil_pkg::BPIL_C_DECEL: begin
                adv_d = decel_tick;
                if (decel_tick && phase_q == `BPIL_LINE_LAST) begin
                    car_d = bpil_pkg::BPIL_C_IDLE;
                end
            end
            default: begin
                car_d = bpil_pkg::BPIL_C_IDLE;
            end
        endcase
        phase_d = adv_d ? phase_q + 3'h1 : phase_q;
        if (por_s) begin
            car_d = bpil_pkg::BPIL_C_IDLE;
            phase_d = '0;
            adv_d = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            car_q <= bpil_pkg::BPIL_C_IDLE;
            phase_q <= '0;
            carriage_advance <= 1'b0;
            carriage_drive_step <= 1'b0;
        end else begin
            car_q <= car_d;
            phase_q <= phase_d;
            carriage_advance <= adv_d;
            carriage_drive_step <= carriage_drive_step ^ adv_d;
        end
    end

    // ****************************************
    // ahb-lite register slave
    // ****************************************
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [8:0] width_us_d;
    logic [31:0] rdata_d;
    logic addr_ok;

    // word decode: low address byte must match, upper 24 address bits must be zero
    function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
        hit = (a[7:0] == off) && (a[31:8] == 24'h0);
    endfunction : hit

    assign addr_ok = hsel & htrans[1] & hready;

    // write data phase, read mux on the address phase
    always_comb begin
        width_us_d = width_us_q;
        if (wr_pend_q && hit({24'h0, wr_addr_q}, `BPIL_OFF_WIDTH)) begin
            // over-range first, so stray upper bits never read as a small width
            if (hwdata[31:9] != 23'h0 || hwdata[8:0] > 9'(`BPIL_IMP_MAX_US)) begin
                width_us_d = 9'(`BPIL_IMP_MAX_US);
            end else if (hwdata[8:0] < 9'(`BPIL_IMP_MIN_US)) begin
                width_us_d = 9'(`BPIL_IMP_MIN_US);
            end else begin
                width_us_d = hwdata[8:0];
            end
        end
        rdata_d = hrdata;
        if (addr_ok && !hwrite) begin
            rdata_d = '0;
            if (hit(haddr, `BPIL_OFF_WIDTH)) begin
                rdata_d[8:0] = width_us_q;
            end else if (hit(haddr, `BPIL_OFF_STATUS)) begin
                rdata_d[`BPIL_ST_MOTION] = belt_in_motion;
                rdata_d[`BPIL_ST_CAR_RUN] = (car_q == bpil_pkg::BPIL_C_RUN);
                rdata_d[`BPIL_ST_CAR_DECEL] = (car_q == bpil_pkg::BPIL_C_DECEL);
                rdata_d[`BPIL_ST_ODD +: `BPIL_GROUPS] = hammer_group_odd;
                rdata_d[`BPIL_ST_THROAT] = throat_closed;
                rdata_d[`BPIL_ST_COVER] = cover_closed;
                rdata_d[`BPIL_ST_FORMS] = forms_present;
                rdata_d[`BPIL_ST_HOT] = over_temp;
            end else if (hit(haddr, `BPIL_OFF_HOMES)) begin
                rdata_d[15:0] = homes_q;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            width_us_q <= `BPIL_WIDTH_RST;
            hrdata <= '0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= (haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hff;
            width_us_q <= width_us_d;
            hrdata <= rdata_d;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [16:0] imp_len_q;
    logic [16:0] imp_w_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            imp_len_q <= '0;
            imp_w_q <= '0;
        end else begin
            imp_len_q <= imp_start ? 17'h1 : imp_len_q + 17'(impression_width_pulse);
            imp_w_q <= imp_start ? width_cyc : imp_w_q;
        end
    end
    sequence decel_entry_s;
        car_q == bpil_pkg::BPIL_C_RUN ##1 car_q == bpil_pkg::BPIL_C_DECEL;
    endsequence
    sequence decel_exit_s;
        car_q == bpil_pkg::BPIL_C_DECEL ##1 car_q == bpil_pkg::BPIL_C_IDLE;
    endsequence

    belt_drive_gate_a: assert property ($changed(belt_drive_step) |-> $past(belt_run_s, 2))
        else $error("belt drive stepped without run request");
    motion_up_a: assert property (mark_rise && !por_s && interval_q <= 20'(RUN_LIM)
        |=> belt_in_motion)
        else $error("belt motion not raised at speed");
    motion_down_a: assert property (mark_rise && !por_s && interval_q > 20'(SLOW_LIM)
        && interval_q <= 20'(GAP_LIM) |=> !belt_in_motion)
        else $error("belt motion kept while slow");
    sub_at_speed_a: assert property ($rose(belt_timing_subpulse) |-> $past(belt_in_motion))
        else $error("subscan while belt not at speed");
    home_dummy_a: assert property (home_pulse |-> belt_timing_subpulse
        && $past(belt_in_motion) && $past(!mark_rise))
        else $error("home pulse without dummy subscan");
    imp_start_a: assert property ($fell(belt_timing_subpulse) |-> impression_width_pulse)
        else $error("impression pulse not started mid-subscan");
    imp_width_a: assert property ($fell(impression_width_pulse)
        |-> $past(imp_len_q) == imp_w_q
        && imp_w_q >= 17'(`BPIL_IMP_MIN_US * `BPIL_CLK_MHZ)
        && imp_w_q <= 17'(`BPIL_IMP_MAX_US * `BPIL_CLK_MHZ))
        else $error("impression pulse width wrong");
    hammer_map_a: assert property (hammer_drive
        == $past(fire_s & {`BPIL_HAMMERS{power_s & ~por_s}}))
        else $error("hammer drive does not follow fire line");
    car_gate_a: assert property (carriage_advance
        |-> $past(car_q != bpil_pkg::BPIL_C_IDLE))
        else $error("carriage advance while idle");
    group_odd_a: assert property (##2
        hammer_group_odd == grp_parity($past(hammer_drive)))
        else $error("group parity line wrong");
    decel_from_six_a: assert property (decel_entry_s |-> phase_q == `BPIL_DECEL_FROM)
        else $error("deceleration not after sixth advance");
    decel_line_end_a: assert property (decel_exit_s |-> phase_q == 3'h0
        && (carriage_advance || $past(por_s)))
        else $error("carriage stopped off a line boundary");
    forms_line_a: assert property (##1 forms_present == $past(pin_s[9]))
        else $error("forms line does not follow switch");
    thermal_lamp_a: assert property (##1 (over_temp == $past(pin_s[10])
        && thermal_fault_lamp == over_temp))
        else $error("thermal lamp differs from overheat line");
endmodule : bpil_top

/* verification/bpil_attach_model.sv */
// attachment side model: printer reset, contactor and line spacing
module bpil_attach_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic space_go,
    input wire logic carriage_advance,
    output logic printer_reset_in,
    output logic contactor_close,
    output logic carriage_run_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] adv_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            printer_reset_in <= 1'b1;
            contactor_close <= 1'b0;
            carriage_run_req <= 1'b0;
            adv_q <= 3'h0;
        end else begin
            printer_reset_in <= 1'b0;
            contactor_close <= 1'b1;
            if (space_go && !carriage_run_req) begin
                carriage_run_req <= 1'b1;
                adv_q <= 3'h0;
            end else if (carriage_advance && carriage_run_req) begin
                adv_q <= adv_q + 3'h1;
                if (adv_q == 3'h5) begin
                    carriage_run_req <= 1'b0;
                end
            end
        end
    end
endmodule : bpil_attach_model

/* verification/test_belt_printer_interface_lines.sv */
// self-checking bench of the belt printer line block
module test_belt_printer_interface_lines;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, space_go, printer_reset_in;
    logic contactor_close, belt_run_req, carriage_run_req, ribbon_stop, clamp_req;
    logic timing_mark, throat_sw, cover_sw, forms_sw, thermal_sw, belt_drive_step;
    logic carriage_drive_step, belt_in_motion, belt_timing_subpulse, impression_width_pulse;
    logic home_pulse, carriage_advance, ribbon_halt, clamp_drive, throat_closed;
    logic cover_closed, forms_present, over_temp, thermal_fault_lamp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize, hammer_group_odd;
    logic [131:0] hammer_fire, hammer_drive;
    int err_count, checks_done, cyc, last_fall, imp_w, sub_n, home_n, car_n, last_adv;
    int btog, ctog;
    int gaps[1:8];
    logic sub_p, imp_p, bstep_p = 1'b0, cstep_p = 1'b0;
    bpil_top #(.MARK_CYC(200), .BELT_STEP_CYC(4), .CAR_STEP_CYC(50), .CAR_DECEL_CYC(100)) dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .printer_reset_in, .contactor_close,
        .belt_run_req, .carriage_run_req, .ribbon_stop, .clamp_req, .hammer_fire, .timing_mark,
        .throat_sw, .cover_sw, .forms_sw, .thermal_sw, .belt_drive_step, .carriage_drive_step,
        .belt_in_motion, .belt_timing_subpulse, .impression_width_pulse, .home_pulse,
        .carriage_advance, .hammer_drive, .hammer_group_odd, .ribbon_halt, .clamp_drive,
        .throat_closed, .cover_closed, .forms_present, .over_temp, .thermal_fault_lamp);
    bpil_attach_model partner (.hclk, .hresetn, .space_go, .carriage_advance,
        .printer_reset_in, .contactor_close, .carriage_run_req);
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(input logic [131:0] seen, input logic [131:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one ahb-lite single word transfer
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
            output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic mark(input int gap);
        timing_mark <= 1'b1;
        repeat (4) @(posedge hclk);
        timing_mark <= 1'b0;
        repeat (gap - 4) @(posedge hclk);
    endtask : mark
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run
    // ****************************************
    // clock, monitor, watchdog
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // edge counts, sampled away from the launch edge
    always @(negedge hclk) begin
        cyc++;
        if (sub_p && !belt_timing_subpulse) begin
            last_fall = cyc;
            chk(impression_width_pulse, 1'b1);
        end
        if (imp_p && !impression_width_pulse) imp_w = cyc - last_fall;
        if (!sub_p && belt_timing_subpulse) sub_n++;
        if (home_pulse) home_n++;
        if (carriage_advance) begin
            car_n++;
            if (car_n <= 8) gaps[car_n] = cyc - last_adv;
            last_adv = cyc;
        end
        if (bstep_p !== belt_drive_step) btog++;
        if (cstep_p !== carriage_drive_step) ctog++;
        {sub_p, imp_p} = {belt_timing_subpulse, impression_width_pulse};
        {bstep_p, cstep_p} = {belt_drive_step, carriage_drive_step};
    end
    initial begin
        repeat (60000) @(posedge hclk);
        err_count++;
        complete_run;
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        logic [31:0] r;
        logic [31:0] wv[4] = '{32'h1f4, 32'h10064, 32'h12c, 32'h64};
        logic [31:0] we[4] = '{32'h1a7, 32'h1a7, 32'h12c, 32'h8c};
        logic [3:0] sv[3] = '{4'hf, 4'h5, 4'ha};
        logic [131:0] hp[2] = '{132'h3 | (132'h1 << 50) | (132'h1 << 100), 132'h1 << 131};
        logic [2:0] ho[2] = '{3'h6, 3'h4};
        int s, h;
        {hresetn, hsel, hwrite, space_go, belt_run_req, ribbon_stop, clamp_req} = '0;
        {timing_mark, throat_sw, cover_sw, forms_sw, thermal_sw, htrans, hsize} = '0;
        {haddr, hwdata, hammer_fire} = '0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({hreadyout, hresp}, 2'h2);
        bus(1'b0, 32'h0, 32'h0, r);
        chk(r, 32'h8c);
        foreach (wv[i]) begin
            bus(1'b1, 32'h0, wv[i], r);
            bus(1'b0, 32'h0, 32'h0, r);
            chk(r, we[i]);
        end
        bus(1'b0, 32'hc, 32'h0, r);
        chk(r, 32'h0);
        foreach (sv[i]) begin
            {throat_sw, cover_sw, forms_sw, thermal_sw} <= sv[i];
            {ribbon_stop, clamp_req} <= sv[i][3:2];
            repeat (5) @(posedge hclk);
            chk({throat_closed, cover_closed, forms_present, over_temp, thermal_fault_lamp,
                ribbon_halt, clamp_drive}, {sv[i], sv[i][0], sv[i][3:2]});
            bus(1'b0, 32'h4, 32'h0, r);
            chk(r[9:6], {sv[i][0], sv[i][1], sv[i][2], sv[i][3]});
        end
        foreach (hp[i]) begin
            hammer_fire <= hp[i];
            repeat (6) @(posedge hclk);
            chk(hammer_drive, hp[i]);
            chk(hammer_group_odd, ho[i]);
        end
        hammer_fire <= '0;
        belt_run_req <= 1'b1;
        repeat (40) @(posedge hclk);
        chk(btog > 4, 1'b1);
        mark(180);
        chk(sub_n, 0);
        repeat (2) mark(180);
        chk(belt_in_motion, 1'b1);
        {s, h} = {sub_n, home_n};
        repeat (2) mark(180);
        mark(360);
        repeat (3) mark(180);
        chk(sub_n - s, 7);
        chk(home_n - h, 1);
        bus(1'b0, 32'h8, 32'h0, r);
        chk(r, 32'h1);
        mark(250);
        mark(20);
        chk(belt_in_motion, 1'b0);
        belt_run_req <= 1'b0;
        repeat (35300) @(posedge hclk);
        chk(imp_w, 35000);
        s = btog;
        repeat (20) @(posedge hclk);
        chk(btog - s, 0);
        space_go <= 1'b1;
        @(posedge hclk);
        space_go <= 1'b0;
        for (int k = 0; k < 2000 && car_n < 8; k++) @(posedge hclk);
        repeat (300) @(posedge hclk);
        chk(car_n, 8);
        chk(ctog, 8);
        chk(gaps[4], 50);
        chk(gaps[8], 100);
        chk(carriage_run_req, 1'b0);
        complete_run;
    end
endmodule : test_belt_printer_interface_lines
